//--- design/block_ram_memory_modes.sv
// multi-mode embedded block ram: dual-port, shift register, rom and fifo
`timescale 1ns/1ps
module block_ram_memory_modes #(
  parameter logic [bram_pkg::MEM_BITS-1:0] INIT_IMAGE = '0,
  parameter int                            SR_WIDTH   = 8,
  parameter int                            SR_TAPS    = 4,
  parameter int                            SR_LEN     = 16,
  parameter int                            FIFO_DEPTH = bram_pkg::FIFO_DEPTH
) (
  input  wire logic                         i_clk,
  input  wire logic                         i_reset,
  input  wire logic [2:0]                   i_mode,
  input  wire logic [bram_pkg::SHAPE_W-1:0] i_a_shape,
  input  wire logic                         i_a_outreg,
  input  wire logic                         i_a_en,
  input  wire logic                         i_a_we,
  input  wire logic [bram_pkg::ADDR_W-1:0]  i_a_addr,
  input  wire logic [bram_pkg::DATA_W-1:0]  i_a_data,
  input  wire logic [bram_pkg::SHAPE_W-1:0] i_b_shape,
  input  wire logic                         i_b_outreg,
  input  wire logic                         i_b_en,
  input  wire logic                         i_b_we,
  input  wire logic [bram_pkg::ADDR_W-1:0]  i_b_addr,
  input  wire logic [bram_pkg::DATA_W-1:0]  i_b_data,
  input  wire logic                         i_sr_shift,
  input  wire logic [SR_WIDTH-1:0]          i_sr_data,
  input  wire logic                         i_fifo_push,
  input  wire logic                         i_fifo_pop,
  input  wire logic [bram_pkg::DATA_W-1:0]  i_fifo_data,
  output logic      [bram_pkg::DATA_W-1:0]  o_a_q,
  output logic      [bram_pkg::DATA_W-1:0]  o_b_q,
  output logic      [SR_WIDTH*SR_TAPS-1:0]  o_sr_taps,
  output logic      [bram_pkg::DATA_W-1:0]  o_fifo_q,
  output logic                              o_fifo_empty,
  output logic                              o_fifo_full,
  output logic                              o_cfg_err
);

  localparam int SR_WORD = SR_WIDTH * SR_TAPS;
  localparam int FIFO_PTR_W = $clog2(FIFO_DEPTH);
  localparam int SR_PTR_W = $clog2(SR_LEN);
  localparam logic [SR_PTR_W-1:0] SR_PTR_LAST = SR_PTR_W'(SR_LEN - 1);
  localparam logic [bram_pkg::DATA_W-1:0] SR_MASK = (36'h0_0000_0001 << SR_WORD) - 36'h0_0000_0001;

  bram_pkg::mem_mode_t mode;

  logic [bram_pkg::DATA_W-1:0]  a_lat_ff;
  logic [bram_pkg::DATA_W-1:0]  b_lat_ff;
  logic [bram_pkg::DATA_W-1:0]  nxt_a_lat;
  logic [bram_pkg::DATA_W-1:0]  nxt_b_lat;
  logic [bram_pkg::DATA_W-1:0]  a_q_ff;
  logic [bram_pkg::DATA_W-1:0]  b_q_ff;
  logic [SR_PTR_W-1:0]          sr_ptr_ff;
  logic [SR_WORD-1:0]           sr_taps_ff;
  logic                         cfg_err_ff;
  logic                         nxt_cfg_err;

  logic                         core_a_we;
  logic [bram_pkg::SHAPE_W-1:0] core_a_shape;
  logic [bram_pkg::ADDR_W-1:0]  core_a_addr;
  logic [bram_pkg::DATA_W-1:0]  core_a_data;
  logic                         core_b_we;
  logic [bram_pkg::SHAPE_W-1:0] core_b_shape;
  logic [bram_pkg::ADDR_W-1:0]  core_b_addr;
  logic [bram_pkg::DATA_W-1:0]  core_b_data;
  logic [bram_pkg::DATA_W-1:0]  rd_a;
  logic [bram_pkg::DATA_W-1:0]  rd_b;
  logic [bram_pkg::DATA_W-1:0]  sr_new_word;

  logic [FIFO_PTR_W-1:0]        fifo_wptr;
  logic [FIFO_PTR_W-1:0]        fifo_rptr;
  logic                         fifo_do_push;
  logic                         fifo_empty;
  logic                         fifo_full;

  logic [bram_pkg::WIDTH_W-1:0] width_a;
  logic [bram_pkg::WIDTH_W-1:0] width_b;

  assign mode    = bram_pkg::mem_mode_t'(i_mode);
  assign width_a = bram_pkg::shape_width(i_a_shape);
  assign width_b = bram_pkg::shape_width(i_b_shape);

  // newest sample enters slot 0, older slots move up one tap
  assign sr_new_word = ((rd_a << SR_WIDTH) | bram_pkg::DATA_W'(i_sr_data)) & SR_MASK;

  // every request is sampled straight on the edge by the array and latches
  ram_core #(
    .INIT_IMAGE (INIT_IMAGE)
  ) u_core (
    .i_clk     (i_clk),
    .i_reset   (i_reset),
    .i_a_we    (core_a_we),
    .i_a_shape (core_a_shape),
    .i_a_addr  (core_a_addr),
    .i_a_data  (core_a_data),
    .o_a_rd    (rd_a),
    .i_b_we    (core_b_we),
    .i_b_shape (core_b_shape),
    .i_b_addr  (core_b_addr),
    .i_b_data  (core_b_data),
    .o_b_rd    (rd_b)
  );

  fifo_ctrl #(
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .i_clk     (i_clk),
    .i_reset   (i_reset),
    .i_push    (i_fifo_push && mode == bram_pkg::MODE_FIFO),
    .i_pop     (i_fifo_pop && mode == bram_pkg::MODE_FIFO),
    .o_wptr    (fifo_wptr),
    .o_rptr    (fifo_rptr),
    .o_do_push (fifo_do_push),
    .o_do_pop  (),
    .o_empty   (fifo_empty),
    .o_full    (fifo_full)
  );

  // routing of the two array ports per mode
  always_comb begin
    core_a_we    = 1'b0;
    core_a_shape = i_a_shape;
    core_a_addr  = i_a_addr;
    core_a_data  = i_a_data;
    core_b_we    = 1'b0;
    core_b_shape = i_b_shape;
    core_b_addr  = i_b_addr;
    core_b_data  = i_b_data;
    unique case (mode)
      bram_pkg::MODE_SDP: begin
        // port a only writes, port b only reads, both in one cycle
        core_a_we = i_a_en && i_a_we;
      end
      bram_pkg::MODE_TDP: begin
        core_a_we = i_a_en && i_a_we;
        core_b_we = i_b_en && i_b_we;
      end
      bram_pkg::MODE_SHIFT: begin
        // one 36-bit word per tap stage; needs SR_LEN up to 128 words
        core_a_shape = bram_pkg::SHAPE_X36;
        core_a_addr  = bram_pkg::ADDR_W'(sr_ptr_ff);
        core_a_data  = sr_new_word;
        core_a_we    = i_sr_shift;
      end
      bram_pkg::MODE_ROM: begin
        core_a_we = 1'b0;
      end
      bram_pkg::MODE_FIFO: begin
        core_a_shape = bram_pkg::SHAPE_X36;
        core_a_addr  = bram_pkg::ADDR_W'(fifo_wptr);
        core_a_data  = i_fifo_data;
        core_a_we    = fifo_do_push;
        core_b_shape = bram_pkg::SHAPE_X36;
        core_b_addr  = bram_pkg::ADDR_W'(fifo_rptr);
      end
      default: begin
        core_a_we = 1'b0;
      end
    endcase
  end

  // next value of the read latches
  always_comb begin
    nxt_a_lat = a_lat_ff;
    nxt_b_lat = b_lat_ff;
    unique case (mode)
      bram_pkg::MODE_SDP: begin
        // single read enable; old contents on a same-address clash
        if (i_b_en) begin
          nxt_b_lat = rd_b;
        end
      end
      bram_pkg::MODE_TDP: begin
        if (i_a_en) begin
          nxt_a_lat = i_a_we ? bram_pkg::mask_to_width(i_a_data, width_a) : rd_a;
        end
        if (i_b_en) begin
          nxt_b_lat = i_b_we ? bram_pkg::mask_to_width(i_b_data, width_b) : rd_b;
        end
      end
      bram_pkg::MODE_ROM: begin
        if (i_a_en) begin
          nxt_a_lat = rd_a;
        end
      end
      bram_pkg::MODE_SHIFT,
      bram_pkg::MODE_FIFO: begin
        nxt_a_lat = a_lat_ff;
      end
      default: begin
        nxt_a_lat = a_lat_ff;
      end
    endcase
  end

  // disabled reads keep the latch, so the output holds its data
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      a_lat_ff <= bram_pkg::OUT_RESET;
      b_lat_ff <= bram_pkg::OUT_RESET;
    end else begin
      a_lat_ff <= nxt_a_lat;
      b_lat_ff <= nxt_b_lat;
    end
  end

  // bypassed: output takes the latch's new value on the same edge
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      a_q_ff <= bram_pkg::OUT_RESET;
      b_q_ff <= bram_pkg::OUT_RESET;
    end else begin
      a_q_ff <= i_a_outreg ? a_lat_ff : nxt_a_lat;
      b_q_ff <= i_b_outreg ? b_lat_ff : nxt_b_lat;
    end
  end

  // shift stage pointer and tap capture
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      sr_ptr_ff  <= '0;
      sr_taps_ff <= '0;
    end else if (mode == bram_pkg::MODE_SHIFT && i_sr_shift) begin
      sr_ptr_ff  <= (sr_ptr_ff == SR_PTR_LAST) ? '0 : sr_ptr_ff + 1'b1;
      sr_taps_ff <= rd_a[SR_WORD-1:0];
    end
  end

  // shape legality for the dual-port modes, and mode codes above 4 in any mode
  always_comb begin
    nxt_cfg_err = 1'b0;
    if (mode == bram_pkg::MODE_SDP || mode == bram_pkg::MODE_TDP) begin
      if (bram_pkg::shape_parity(i_a_shape) != bram_pkg::shape_parity(i_b_shape)) begin
        nxt_cfg_err = 1'b1;
      end
      if (width_a == '0 || width_b == '0) begin
        nxt_cfg_err = 1'b1;
      end
    end
    if (mode == bram_pkg::MODE_TDP) begin
      if (width_a > bram_pkg::TDP_MAX_WIDTH || width_b > bram_pkg::TDP_MAX_WIDTH) begin
        nxt_cfg_err = 1'b1;
      end
    end
    if (i_mode > 3'h4) begin
      nxt_cfg_err = 1'b1;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      cfg_err_ff <= 1'b0;
    end else begin
      cfg_err_ff <= nxt_cfg_err;
    end
  end

  assign o_a_q        = a_q_ff;
  assign o_b_q        = b_q_ff;
  assign o_sr_taps    = sr_taps_ff;
  // unregistered head word; zero while empty, so reset shows zero
  assign o_fifo_q     = (mode == bram_pkg::MODE_FIFO && !fifo_empty) ? rd_b : bram_pkg::OUT_RESET;
  assign o_fifo_empty = fifo_empty;
  assign o_fifo_full  = fifo_full;
  assign o_cfg_err    = cfg_err_ff;

endmodule

//--- design/bram_pkg.sv
// constants, shape table and mode enumeration for the block ram
// Overview of operation
// - simple dual-port takes one write and one read in the same cycle.
// - simple dual-port widths mix within x1..x32 or within x9/x18/x36 only.
// - simple dual-port has one write enable, one read enable, neither clearable.
// - simple dual-port output holds last read data while read enable is low.
// - simple dual-port same-address read during write returns the old data.
// - true dual-port ports each read or write independently, any combination.
// - true dual-port ports are at most 16 bits, or 18 with parity.
// - true dual-port widths mix within x1..x16 or within x9/x18 only.
// - true dual-port write data flows through to the writing port's output.
// - with output register bypassed, write data shows after that same edge.
// - shift mode writes and reads each location within one clock cycle.
// - rom contents come preloaded; address registered; read as single-port.
// - fifo inputs are synchronous, fifo data output is combinational.
// - address, data and enables are all captured on the clock edge.
// - outputs read zero after reset; first real read returns preloaded content.
package bram_pkg;

  typedef enum logic [2:0] {
    MODE_SDP,
    MODE_TDP,
    MODE_SHIFT,
    MODE_ROM,
    MODE_FIFO
  } mem_mode_t;

  localparam int MEM_BITS = 4608;
  localparam int ADDR_W   = 12;
  localparam int DATA_W   = 36;
  localparam int SHAPE_W  = 4;
  localparam int WIDTH_W  = 6;

  localparam logic [SHAPE_W-1:0] SHAPE_X1  = 4'h0;
  localparam logic [SHAPE_W-1:0] SHAPE_X2  = 4'h1;
  localparam logic [SHAPE_W-1:0] SHAPE_X4  = 4'h2;
  localparam logic [SHAPE_W-1:0] SHAPE_X8  = 4'h3;
  localparam logic [SHAPE_W-1:0] SHAPE_X16 = 4'h4;
  localparam logic [SHAPE_W-1:0] SHAPE_X32 = 4'h5;
  localparam logic [SHAPE_W-1:0] SHAPE_X9  = 4'h6;
  localparam logic [SHAPE_W-1:0] SHAPE_X18 = 4'h7;
  localparam logic [SHAPE_W-1:0] SHAPE_X36 = 4'h8;

  localparam logic [WIDTH_W-1:0] TDP_MAX_WIDTH = 6'h12;
  localparam logic [DATA_W-1:0]  OUT_RESET     = 36'h0_0000_0000;
  localparam int                 FIFO_DEPTH    = 128;
  localparam int                 SR_MAX_LEN    = 128;

  function automatic logic [WIDTH_W-1:0] shape_width(input logic [SHAPE_W-1:0] s);
    case (s)
      SHAPE_X1:  return 6'h01;
      SHAPE_X2:  return 6'h02;
      SHAPE_X4:  return 6'h04;
      SHAPE_X8:  return 6'h08;
      SHAPE_X16: return 6'h10;
      SHAPE_X32: return 6'h20;
      SHAPE_X9:  return 6'h09;
      SHAPE_X18: return 6'h12;
      SHAPE_X36: return 6'h24;
      default:   return 6'h00;
    endcase
  endfunction

  function automatic logic shape_parity(input logic [SHAPE_W-1:0] s);
    return (s == SHAPE_X9) || (s == SHAPE_X18) || (s == SHAPE_X36);
  endfunction

  function automatic logic [DATA_W-1:0] mask_to_width(input logic [DATA_W-1:0] d,
                                                      input logic [WIDTH_W-1:0] w);
    logic [DATA_W-1:0] r;
    r = '0;
    for (int i = 0; i < DATA_W; i++) begin
      if (i < int'(w)) begin
        r[i] = d[i];
      end
    end
    return r;
  endfunction

endpackage

//--- design/ram_core.sv
// bit-addressed two-port storage array with per-port shape
`timescale 1ns/1ps
module ram_core #(
  parameter logic [bram_pkg::MEM_BITS-1:0] INIT_IMAGE = '0
) (
  input  wire logic                         i_clk,
  input  wire logic                         i_reset,
  input  wire logic                         i_a_we,
  input  wire logic [bram_pkg::SHAPE_W-1:0] i_a_shape,
  input  wire logic [bram_pkg::ADDR_W-1:0]  i_a_addr,
  input  wire logic [bram_pkg::DATA_W-1:0]  i_a_data,
  output logic      [bram_pkg::DATA_W-1:0]  o_a_rd,
  input  wire logic                         i_b_we,
  input  wire logic [bram_pkg::SHAPE_W-1:0] i_b_shape,
  input  wire logic [bram_pkg::ADDR_W-1:0]  i_b_addr,
  input  wire logic [bram_pkg::DATA_W-1:0]  i_b_data,
  output logic      [bram_pkg::DATA_W-1:0]  o_b_rd
);

  logic [bram_pkg::MEM_BITS-1:0] mem_ff;
  logic [17:0]                   base_a;
  logic [17:0]                   base_b;
  logic [bram_pkg::WIDTH_W-1:0]  width_a;
  logic [bram_pkg::WIDTH_W-1:0]  width_b;

  function automatic logic [bram_pkg::DATA_W-1:0] read_word(input logic [bram_pkg::MEM_BITS-1:0] m,
                                                            input logic [17:0] base,
                                                            input logic [bram_pkg::WIDTH_W-1:0] w);
    logic [bram_pkg::DATA_W-1:0] r;
    r = '0;
    for (int i = 0; i < bram_pkg::DATA_W; i++) begin
      if (i < int'(w) && int'(base) + i < bram_pkg::MEM_BITS) begin
        r[i] = m[int'(base) + i];
      end
    end
    return r;
  endfunction

  assign width_a = bram_pkg::shape_width(i_a_shape);
  assign width_b = bram_pkg::shape_width(i_b_shape);
  // widen before the product so x36 addresses past 113 keep their top bit
  assign base_a  = 18'(i_a_addr) * 18'(width_a);
  assign base_b  = 18'(i_b_addr) * 18'(width_b);

  // read sees contents before this edge's write
  assign o_a_rd = read_word(mem_ff, base_a, width_a);
  assign o_b_rd = read_word(mem_ff, base_b, width_b);

  // port b follows port a at each bit offset, so a same-shape same-address clash leaves port b's bit
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      mem_ff <= INIT_IMAGE;
    end else begin
      for (int i = 0; i < bram_pkg::DATA_W; i++) begin
        if (i_a_we && i < int'(width_a) && int'(base_a) + i < bram_pkg::MEM_BITS) begin
          mem_ff[int'(base_a) + i] <= i_a_data[i];
        end
        if (i_b_we && i < int'(width_b) && int'(base_b) + i < bram_pkg::MEM_BITS) begin
          mem_ff[int'(base_b) + i] <= i_b_data[i];
        end
      end
    end
  end

endmodule

//--- design/fifo_ctrl.sv
// fifo pointer, occupancy and flag control
`timescale 1ns/1ps
module fifo_ctrl #(
  parameter int DEPTH = bram_pkg::FIFO_DEPTH,
  parameter int PTR_W = $clog2(DEPTH)
) (
  input  wire logic             i_clk,
  input  wire logic             i_reset,
  input  wire logic             i_push,
  input  wire logic             i_pop,
  output logic      [PTR_W-1:0] o_wptr,
  output logic      [PTR_W-1:0] o_rptr,
  output logic                  o_do_push,
  output logic                  o_do_pop,
  output logic                  o_empty,
  output logic                  o_full
);

  localparam logic [PTR_W:0]   CNT_FULL = (PTR_W+1)'(DEPTH);
  localparam logic [PTR_W-1:0] PTR_LAST = PTR_W'(DEPTH - 1);

  logic [PTR_W-1:0] wptr_ff;
  logic [PTR_W-1:0] rptr_ff;
  logic [PTR_W:0]   count_ff;
  logic [PTR_W:0]   nxt_count;
  logic             empty_ff;
  logic             full_ff;

  // a pop on an empty fifo is refused even alongside a push
  assign o_do_pop  = i_pop && !empty_ff;
  assign o_do_push = i_push && !full_ff;
  assign o_wptr    = wptr_ff;
  assign o_rptr    = rptr_ff;
  assign o_empty   = empty_ff;
  assign o_full    = full_ff;

  always_comb begin
    nxt_count = count_ff;
    if (o_do_push && !o_do_pop) begin
      nxt_count = count_ff + 1'b1;
    end else if (o_do_pop && !o_do_push) begin
      nxt_count = count_ff - 1'b1;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      wptr_ff <= '0;
      rptr_ff <= '0;
    end else begin
      if (o_do_push) begin
        wptr_ff <= (wptr_ff == PTR_LAST) ? '0 : wptr_ff + 1'b1;
      end
      if (o_do_pop) begin
        rptr_ff <= (rptr_ff == PTR_LAST) ? '0 : rptr_ff + 1'b1;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      count_ff <= '0;
      empty_ff <= 1'b1;
      full_ff  <= 1'b0;
    end else begin
      count_ff <= nxt_count;
      empty_ff <= (nxt_count == '0);
      full_ff  <= (nxt_count == CNT_FULL);
    end
  end

endmodule

//--- verif/user_port_model.sv
// far-side user logic driving one memory port
`timescale 1ns/1ps
module user_port_model (
  output logic        o_en,
  output logic        o_we,
  output logic [11:0] o_addr,
  output logic [35:0] o_data
);
  initial begin
    o_en = 1'h0;
    o_we = 1'h0;
    o_addr = 12'h000;
    o_data = 36'h0;
  end
  // caller keeps the two ports off one address while both write
  task automatic put(input logic en, we, input logic [11:0] addr, input logic [35:0] data);
    o_en = en;
    o_we = en & we;
    // released lines flip so stale values never look valid
    o_addr = en ? addr : ~o_addr;
    o_data = (en & we) ? data : ~o_data;
  endtask
endmodule

//--- verif/bram_props_properties.sv
// concurrent checks on the block ram top-level ports
`timescale 1ns/1ps
module bram_props #(
  parameter int SR_WIDTH = 8,
  parameter int SR_TAPS  = 4
) (
  input wire logic                        i_clk,
  input wire logic                        i_reset,
  input wire logic [2:0]                  i_mode,
  input wire logic [3:0]                  i_a_shape,
  input wire logic                        i_a_outreg,
  input wire logic                        i_a_en,
  input wire logic                        i_a_we,
  input wire logic [35:0]                 i_a_data,
  input wire logic [3:0]                  i_b_shape,
  input wire logic                        i_b_outreg,
  input wire logic                        i_b_en,
  input wire logic                        i_sr_shift,
  input wire logic                        i_fifo_push,
  input wire logic [35:0]                 o_a_q,
  input wire logic [35:0]                 o_b_q,
  input wire logic [SR_WIDTH*SR_TAPS-1:0] o_sr_taps,
  input wire logic [35:0]                 o_fifo_q,
  input wire logic                        o_fifo_empty,
  input wire logic                        o_fifo_full,
  input wire logic                        o_cfg_err
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_reset);
  sequence s_tdp_x18;
    i_mode == 3'h1 && i_a_shape == 4'h7 && i_b_shape == 4'h7;
  endsequence
  sequence s_a_write;
    s_tdp_x18 ##0 (i_a_en && i_a_we && !i_a_outreg);
  endsequence
  a_reset_clears: assert property (disable iff (1'h0) i_reset |=> o_a_q == '0 && o_b_q == '0
    && o_sr_taps == '0 && o_fifo_empty && !o_fifo_full && !o_cfg_err) else $error("reset left outputs set");
  a_read_hold: assert property (i_mode == 3'h0 && !i_b_en && !i_b_outreg |=> $stable(o_b_q))
    else $error("read output moved without read enable");
  a_write_quiet: assert property (i_mode == 3'h0 |=> $stable(o_a_q))
    else $error("write-only port output moved");
  a_write_flows: assert property (s_a_write |=> o_a_q == {18'h0, $past(i_a_data[17:0])})
    else $error("written data not on own output");
  a_wide_tdp: assert property (i_mode == 3'h1 && i_a_shape == 4'h8 |-> ##2 o_cfg_err)
    else $error("wide dual-port shape accepted");
  a_family_mix: assert property ((i_mode == 3'h0 || i_mode == 3'h1) && i_a_shape <= 4'h5
    && i_b_shape >= 4'h6 && i_b_shape <= 4'h8 |-> ##2 o_cfg_err) else $error("mixed shape families accepted");
  a_empty_stays: assert property (i_mode == 3'h4 && o_fifo_empty && !i_fifo_push |=> o_fifo_empty)
    else $error("empty flag dropped without push");
  a_push_fills: assert property (i_mode == 3'h4 && i_fifo_push && !o_fifo_full |=> !o_fifo_empty)
    else $error("accepted push left fifo empty");
  a_flags_apart: assert property (!(o_fifo_empty && o_fifo_full))
    else $error("empty and full together");
  a_fifo_idle: assert property (i_mode != 3'h4 |-> o_fifo_q == '0)
    else $error("fifo data outside fifo mode");
  a_shift_hold: assert property (i_mode == 3'h2 && !i_sr_shift |=> $stable(o_sr_taps))
    else $error("taps moved without shift");
endmodule
bind block_ram_memory_modes bram_props #(.SR_WIDTH(SR_WIDTH), .SR_TAPS(SR_TAPS)) u_props (
  .i_clk, .i_reset, .i_mode, .i_a_shape, .i_a_outreg, .i_a_en, .i_a_we, .i_a_data, .i_b_shape,
  .i_b_outreg, .i_b_en, .i_sr_shift, .i_fifo_push, .o_a_q, .o_b_q, .o_sr_taps, .o_fifo_q,
  .o_fifo_empty, .o_fifo_full, .o_cfg_err
);

//--- verif/block_ram_memory_modes_tb_top.sv
// self-checking bench for the multi-mode block ram
`timescale 1ns/1ps
module block_ram_memory_modes_tb_top;
  localparam logic [4607:0] IMG = {144{32'h5a3c_96e1}};
  localparam int            SL  = 4;
  localparam int            FD  = 4;
  typedef struct {int due; int sel; logic [35:0] v;} note_t;
  logic        i_clk = 1'h0;
  logic        i_reset = 1'h1;
  logic [2:0]  i_mode = 3'h3;
  logic [3:0]  i_a_shape = 4'h7;
  logic [3:0]  i_b_shape = 4'h7;
  logic        i_a_outreg = 1'h0;
  logic        i_b_outreg = 1'h0;
  logic        i_sr_shift = 1'h0;
  logic [7:0]  i_sr_data = 8'h00;
  logic        i_fifo_push = 1'h0;
  logic        i_fifo_pop = 1'h0;
  logic [35:0] i_fifo_data = 36'h0;
  wire logic   a_en, a_we, b_en, b_we;
  wire logic [11:0] a_addr, b_addr;
  wire logic [35:0] a_data, b_data;
  logic [35:0] o_a_q, o_b_q, o_fifo_q, d, e;
  logic [35:0] w [5];
  logic [31:0] o_sr_taps, tp;
  logic        o_fifo_empty, o_fifo_full, o_cfg_err;
  logic [7:0]  s [24];
  logic [15:0] cfg [7] = '{16'h1871, 16'h1751, 16'h0361, 16'h1461, 16'h1420, 16'h0870, 16'h5771};
  int          err_count = 0;
  int          n_tests = 0;
  int          cyc = 0;
  note_t       q [$];
  always #2 i_clk = ~i_clk;
  always @(posedge i_clk) cyc <= cyc + 1;
  user_port_model u_pa (.o_en(a_en), .o_we(a_we), .o_addr(a_addr), .o_data(a_data));
  user_port_model u_pb (.o_en(b_en), .o_we(b_we), .o_addr(b_addr), .o_data(b_data));
  block_ram_memory_modes #(.INIT_IMAGE(IMG), .SR_LEN(SL), .FIFO_DEPTH(FD)) u_dut (
    .i_clk(i_clk), .i_reset(i_reset), .i_mode(i_mode), .i_a_shape(i_a_shape), .i_a_outreg(i_a_outreg),
    .i_a_en(a_en), .i_a_we(a_we), .i_a_addr(a_addr), .i_a_data(a_data), .i_b_shape(i_b_shape),
    .i_b_outreg(i_b_outreg), .i_b_en(b_en), .i_b_we(b_we), .i_b_addr(b_addr), .i_b_data(b_data),
    .i_sr_shift(i_sr_shift), .i_sr_data(i_sr_data), .i_fifo_push(i_fifo_push), .i_fifo_pop(i_fifo_pop),
    .i_fifo_data(i_fifo_data), .o_a_q(o_a_q), .o_b_q(o_b_q), .o_sr_taps(o_sr_taps), .o_fifo_q(o_fifo_q),
    .o_fifo_empty(o_fifo_empty), .o_fifo_full(o_fifo_full), .o_cfg_err(o_cfg_err));
  task automatic check(input logic [35:0] seen, input logic [35:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  function automatic logic [35:0] pick(input int sel);
    case (sel)
      0: return o_a_q;
      1: return o_b_q;
      2: return o_fifo_q;
      3: return {34'h0, o_fifo_full, o_fifo_empty};
      4: return {4'h0, o_sr_taps};
      default: return {35'h0, o_cfg_err};
    endcase
  endfunction
  // oldest note is compared once its cycle has come
  always @(posedge i_clk) begin
    #1;
    while (q.size() > 0 && q[0].due <= cyc) begin
      check(pick(q[0].sel), q[0].v);
      void'(q.pop_front());
    end
  end
  task automatic expect_at(input int lat, input int sel, input logic [35:0] v);
    q.push_back('{cyc + lat, sel, v});
  endtask
  task automatic ab(input logic ae, aw, input logic [11:0] aa, input logic [35:0] ad,
                    input logic be, bw, input logic [11:0] ba, input logic [35:0] bd);
    @(negedge i_clk);
    u_pa.put(ae, aw, aa, ad);
    u_pb.put(be, bw, ba, bd);
  endtask
  task automatic ff(input logic push, pop, input logic [35:0] dat);
    @(negedge i_clk);
    i_fifo_push = push;
    i_fifo_pop = pop;
    i_fifo_data = push ? dat : ~i_fifo_data;
  endtask
  task automatic restart(input logic [2:0] m, input logic [3:0] sa, sb);
    // let pending results and two-cycle checks finish before reset
    if (!i_reset) repeat (3) @(negedge i_clk);
    i_reset = 1'h1;
    i_mode = m;
    i_a_shape = sa;
    i_b_shape = sb;
    repeat (3) @(negedge i_clk);
    u_pa.put(1'h0, 1'h0, 12'h000, 36'h0);
    u_pb.put(1'h0, 1'h0, 12'h000, 36'h0);
    i_reset = 1'h0;
    expect_at(1, 2, 36'h0);
    expect_at(1, 0, 36'h0);
    expect_at(1, 1, 36'h0);
    expect_at(1, 3, 36'h1);
  endtask
  task automatic end_of_test();
    $display("tests %0d errors %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  initial begin
    void'($urandom(14226));
    foreach (w[i]) w[i] = 36'({$urandom, $urandom});
    foreach (s[i]) s[i] = 8'($urandom);
    i_a_outreg = 1'h1;
    restart(3'h3, 4'h8, 4'h7);
    ab(1'h1, 1'h1, 12'h002, 36'h0, 1'h1, 1'h0, 12'h002, 36'h0);
    expect_at(1, 0, 36'h0);
    expect_at(2, 0, IMG[72+:36]);
    ab(1'h1, 1'h0, 12'h003, 36'h0, 1'h0, 1'h0, 12'h000, 36'h0);
    expect_at(2, 0, IMG[108+:36]);
    d = 36'($urandom);
    restart(3'h0, 4'h3, 4'h4);
    i_a_outreg = 1'h0;
    ab(1'h1, 1'h1, 12'h002, {28'h0, d[7:0]}, 1'h0, 1'h0, 12'h000, 36'h0);
    ab(1'h1, 1'h1, 12'h003, {28'h0, d[15:8]}, 1'h0, 1'h0, 12'h000, 36'h0);
    ab(1'h1, 1'h1, 12'h003, {28'h0, d[23:16]}, 1'h1, 1'h0, 12'h001, 36'h0);
    expect_at(1, 1, {20'h0, d[15:0]});
    ab(1'h1, 1'h1, 12'h002, {28'h0, d[31:24]}, 1'h0, 1'h0, 12'h000, 36'h0);
    expect_at(1, 1, {20'h0, d[15:0]});
    expect_at(1, 0, 36'h0);
    ab(1'h0, 1'h0, 12'h000, 36'h0, 1'h1, 1'h0, 12'h001, 36'h0);
    expect_at(1, 1, {20'h0, d[23:16], d[31:24]});
    d = w[3];
    e = w[4];
    restart(3'h1, 4'h7, 4'h7);
    ab(1'h1, 1'h1, 12'h005, d, 1'h1, 1'h1, 12'h006, e);
    expect_at(1, 0, {18'h0, d[17:0]});
    expect_at(1, 1, {18'h0, e[17:0]});
    ab(1'h1, 1'h0, 12'h006, 36'h0, 1'h1, 1'h0, 12'h005, 36'h0);
    expect_at(1, 0, {18'h0, e[17:0]});
    expect_at(1, 1, {18'h0, d[17:0]});
    ab(1'h0, 1'h0, 12'h000, 36'h0, 1'h0, 1'h0, 12'h000, 36'h0);
    foreach (cfg[i]) begin
      restart(cfg[i][14:12], cfg[i][11:8], cfg[i][7:4]);
      expect_at(2, 5, {35'h0, cfg[i][0]});
    end
    restart(3'h2, 4'h7, 4'h7);
    for (int n = 0; n < 24; n++) begin
      @(negedge i_clk);
      i_sr_shift = 1'h1;
      i_sr_data = s[n];
      for (int j = 0; j < 4; j++) tp[j*8+:8] = (n >= (j + 1) * SL) ? s[n-(j+1)*SL] : 8'h00;
      if (n >= 4 * SL) expect_at(1, 4, {4'h0, tp});
    end
    @(negedge i_clk);
    i_sr_shift = 1'h0;
    repeat (2) @(negedge i_clk);
    restart(3'h4, 4'h7, 4'h7);
    for (int i = 0; i < 5; i++) begin
      ff(1'h1, 1'h0, w[i]);
      expect_at(1, 3, {34'h0, i >= FD - 1, 1'h0});
      expect_at(1, 2, w[0]);
    end
    // pops never meet an empty fifo together with a push
    for (int i = 0; i < 5; i++) begin
      ff(1'h0, 1'h1, 36'h0);
      expect_at(1, 3, {35'h0, i >= FD - 1});
      if (i < FD - 1) expect_at(1, 2, w[i+1]);
    end
    ff(1'h0, 1'h0, 36'h0);
    for (int i = 0; i < 10 && q.size() > 0; i++) @(posedge i_clk);
    if (q.size() > 0) err_count++;
    end_of_test();
  end
  initial begin
    #100000;
    err_count++;
    end_of_test();
  end
endmodule
